/* hdl/dwd_addr_decode.sv */
// Purpose: Expands an 8-bit write address into a 32-channel select mask
// Assumes: Channel index is group times eight plus position
// Notes: Purely combinational
`timescale 1ns/1ps
module dwd_addr_decode (
  // Address in
  input wire logic [dwd_pkg::ADDR_W-1:0] write_address,
  // Select out
  output logic [dwd_pkg::NUM_CH-1:0] channel_select
);

  logic [dwd_pkg::GRP_MSB-dwd_pkg::GRP_LSB:0] group_field;
  logic [dwd_pkg::POS_MSB:0] pos_code;
  logic [dwd_pkg::POS_W-1:0] pos;
  logic pos_valid;

  assign group_field = write_address[dwd_pkg::GRP_MSB:dwd_pkg::GRP_LSB];
  assign pos_code = write_address[dwd_pkg::POS_MSB:0];

  always_comb begin
    pos = '0;
    pos_valid = 1'b0;
    if (pos_code <= dwd_pkg::POS_CODE_LOW_MAX) begin
      pos = pos_code[dwd_pkg::POS_W-1:0];
      pos_valid = 1'b1;
    end else if (pos_code == dwd_pkg::POS_CODE_6) begin
      pos = dwd_pkg::POS_6;
      pos_valid = 1'b1;
    end else if (pos_code == dwd_pkg::POS_CODE_7) begin
      pos = dwd_pkg::POS_7;
      pos_valid = 1'b1;
    end
  end

  always_comb begin
    channel_select = '0;
    if (group_field == dwd_pkg::GRP_ALL) begin
      channel_select = '1;
    end else if (pos_valid) begin
      for (int g = 0; g < dwd_pkg::NUM_GRP; g++) begin
        channel_select[g * dwd_pkg::CH_PER_GRP + int'(pos)] = group_field[g];
      end
    end
  end

endmodule : dwd_addr_decode

/* hdl/dwd_channel.sv */
// Purpose: One channel's input, offset and gain registers
// Assumes: Operation and data are valid for one cycle
// Notes: Soft reset acts regardless of the select input
`timescale 1ns/1ps
module dwd_channel (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Command
  input wire logic select,
  input wire dwd_pkg::dwd_op_type op,
  input wire logic [dwd_pkg::DATA_W-1:0] data,
  // State
  output dwd_pkg::dwd_chan_type state
);

  logic [dwd_pkg::DATA_W-1:0] input_reg;
  logic [dwd_pkg::DATA_W-1:0] input_next;
  logic [dwd_pkg::DATA_W-1:0] offset_reg;
  logic [dwd_pkg::GAIN_W-1:0] gain_reg;
  logic [dwd_pkg::DATA_W:0] step_sum;
  logic [dwd_pkg::DATA_W-1:0] step_size;

  assign step_size = {{(dwd_pkg::DATA_W-dwd_pkg::STEP_W){1'b0}}, data[dwd_pkg::STEP_W-1:0]};
  assign step_sum = {1'b0, input_reg} + {1'b0, step_size};

  // ---------------------------------------------------------------
  // Step with saturation
  // ---------------------------------------------------------------
  always_comb begin
    if (data[dwd_pkg::STEP_DIR_BIT]) begin
      input_next = step_sum[dwd_pkg::DATA_W] ? dwd_pkg::CODE_MAX : step_sum[dwd_pkg::DATA_W-1:0];
    end else begin
      input_next = (input_reg < step_size) ? dwd_pkg::CODE_MIN : input_reg - step_size;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_reg <= dwd_pkg::INPUT_RESET;
    end else if (op == dwd_pkg::OP_RESET) begin
      input_reg <= dwd_pkg::INPUT_RESET;
    end else if (select && op == dwd_pkg::OP_INPUT) begin
      input_reg <= data;
    end else if (select && op == dwd_pkg::OP_STEP) begin
      input_reg <= input_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_reg <= dwd_pkg::OFFSET_RESET;
    end else if (op == dwd_pkg::OP_RESET) begin
      offset_reg <= dwd_pkg::OFFSET_RESET;
    end else if (select && op == dwd_pkg::OP_OFFSET) begin
      offset_reg <= data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg <= dwd_pkg::GAIN_RESET;
    end else if (op == dwd_pkg::OP_RESET) begin
      gain_reg <= dwd_pkg::GAIN_RESET;
    end else if (select && op == dwd_pkg::OP_GAIN) begin
      gain_reg <= data[dwd_pkg::GAIN_W-1:0];
    end
  end

  assign state = '{channel_input_code: input_reg, offset_code: offset_reg, gain_code: gain_reg};

endmodule : dwd_channel

/* hdl/dwd_decoder.sv */
// Purpose: Decodes DAC write words into per-channel register updates
// Assumes: Write words arrive on ref_clk from a front end in the same domain
// Notes: Read-back state lags one cycle, calibrated code two cycles
//
// Overview of operation
// - Steer 14-bit word by two-bit selector
// - Selector 11 loads straight binary input code
// - Selector 10 loads offset-binary offset
// - Selector 01 loads gain code, gain (code+1)/8192
// - Selector 00 steps input code up to 127
// - All-ones special word grounds every output
// - Address high nibble groups, low nibble position
// - Zero group field writes all 32 channels
// - Group bits enable groups A to D
// - Eight position codes map to positions 0-7
// - Direction bit one adds, zero subtracts
// - Steps saturate at full or zero scale
// - Soft reset restores all channel registers
`timescale 1ns/1ps
module dwd_decoder (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Write command
  input wire logic write_valid,
  input wire dwd_pkg::dwd_write_type write_cmd,
  // Output update control
  input wire logic output_update,
  // Read-back select
  input wire logic [dwd_pkg::CH_IDX_W-1:0] rd_channel,
  // Read-back data
  output dwd_pkg::dwd_chan_type rd_state,
  output logic [dwd_pkg::DATA_W-1:0] rd_calibrated_code,
  // Status
  output logic outputs_grounded,
  output logic write_done,
  output logic write_ignored,
  output logic soft_reset_done
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  dwd_pkg::dwd_op_type op;
  logic [1:0] reg_sel;
  logic [dwd_pkg::NUM_CH-1:0] channel_select;
  dwd_pkg::dwd_chan_type chan_state [dwd_pkg::NUM_CH];
  dwd_pkg::dwd_chan_type rd_state_reg;
  logic [dwd_pkg::DATA_W-1:0] rd_calibrated_reg;
  logic grounded_reg;
  logic write_done_reg;
  logic write_ignored_reg;
  logic soft_reset_reg;
  logic is_ignored;
  logic [dwd_pkg::DATA_W-1:0] gain_plus_one;
  logic [dwd_pkg::PROD_W-1:0] cal_product;
  logic [dwd_pkg::CAL_W-1:0] cal_scaled;
  logic signed [dwd_pkg::CAL_W-1:0] cal_sum;
  logic [dwd_pkg::DATA_W-1:0] cal_next;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  assign reg_sel = {write_cmd.reg_select_hi, write_cmd.reg_select_lo};

  always_comb begin
    op = dwd_pkg::OP_NONE;
    if (write_valid) begin
      case (reg_sel)
        dwd_pkg::SEL_INPUT: begin
          op = dwd_pkg::OP_INPUT;
        end
        dwd_pkg::SEL_OFFSET: begin
          op = dwd_pkg::OP_OFFSET;
        end
        dwd_pkg::SEL_GAIN: begin
          op = dwd_pkg::OP_GAIN;
        end
        dwd_pkg::SEL_SPECIAL: begin
          if (write_cmd.write_data_word == dwd_pkg::SOFT_RESET_WORD) begin
            op = dwd_pkg::OP_RESET;
          end else begin
            op = dwd_pkg::OP_STEP;
          end
        end
        default: begin
          op = dwd_pkg::OP_NONE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  dwd_addr_decode u_addr_decode (
    .write_address(write_cmd.write_address),
    .channel_select(channel_select)
  );

  // Soft reset ignores the address; anything else with no channel hit is dropped
  assign is_ignored = (op != dwd_pkg::OP_NONE) && (op != dwd_pkg::OP_RESET) && (channel_select == '0);

  // ---------------------------------------------------------------
  // Channel registers
  // ---------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < dwd_pkg::NUM_CH; ch++) begin : g_chan
      dwd_channel u_channel (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .select(channel_select[ch]),
        .op(op),
        .data(write_cmd.write_data_word),
        .state(chan_state[ch])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Output ground control
  // ---------------------------------------------------------------
  // Outputs stay at ground from soft reset until the next update; set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      grounded_reg <= 1'b1;
    end else if (op == dwd_pkg::OP_RESET) begin
      grounded_reg <= 1'b1;
    end else if (output_update) begin
      grounded_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Status pulses
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_done_reg <= 1'b0;
    end else begin
      write_done_reg <= (op != dwd_pkg::OP_NONE) && !is_ignored;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_ignored_reg <= 1'b0;
    end else begin
      write_ignored_reg <= is_ignored;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= (op == dwd_pkg::OP_RESET);
    end
  end

  // ---------------------------------------------------------------
  // Read-back stage
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_reg <= '{channel_input_code: dwd_pkg::INPUT_RESET,
                        offset_code: dwd_pkg::OFFSET_RESET,
                        gain_code: dwd_pkg::GAIN_RESET};
    end else begin
      rd_state_reg <= chan_state[rd_channel];
    end
  end

  // ---------------------------------------------------------------
  // Calibrated code
  // ---------------------------------------------------------------
  // Input times (gain+1)/8192 plus offset less mid-scale, clamped to the code range
  assign gain_plus_one = {1'b0, rd_state_reg.gain_code} + 14'h0001;
  assign cal_product = dwd_pkg::PROD_W'(rd_state_reg.channel_input_code) * dwd_pkg::PROD_W'(gain_plus_one);
  assign cal_scaled = dwd_pkg::CAL_W'(cal_product >> dwd_pkg::CAL_SHIFT);
  assign cal_sum = $signed(cal_scaled) + $signed(dwd_pkg::CAL_W'(rd_state_reg.offset_code))
                   - $signed(dwd_pkg::CAL_OFFSET_ZERO);

  always_comb begin
    if (cal_sum < 0) begin
      cal_next = dwd_pkg::CODE_MIN;
    end else if (cal_sum > $signed(dwd_pkg::CAL_CODE_MAX)) begin
      cal_next = dwd_pkg::CODE_MAX;
    end else begin
      cal_next = cal_sum[dwd_pkg::DATA_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_calibrated_reg <= dwd_pkg::CODE_MIN;
    end else begin
      rd_calibrated_reg <= cal_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rd_state = rd_state_reg;
  assign rd_calibrated_code = rd_calibrated_reg;
  assign outputs_grounded = grounded_reg;
  assign write_done = write_done_reg;
  assign write_ignored = write_ignored_reg;
  assign soft_reset_done = soft_reset_reg;

endmodule : dwd_decoder

/* hdl/dwd_pkg.sv */
// Purpose: Shared constants and types for the DAC write decoder
// Assumes: 14-bit data words, 8-bit addresses, 32 channels in four groups of eight
// Notes: Power-on values give zero input, zero offset and unity gain
package dwd_pkg;

  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int DATA_W = 14;
  localparam int GAIN_W = 13;
  localparam int ADDR_W = 8;
  localparam int NUM_CH = 32;
  localparam int NUM_GRP = 4;
  localparam int CH_PER_GRP = 8;
  localparam int POS_W = 3;
  localparam int CH_IDX_W = 5;
  localparam int STEP_W = 7;
  localparam int PROD_W = 28;
  localparam int CAL_W = 17;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int STEP_DIR_BIT = 8;
  localparam int GRP_LSB = 4;
  localparam int GRP_MSB = 7;
  localparam int POS_MSB = 3;
  localparam int CAL_SHIFT = 13;

  // ---------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_INPUT = 2'h3;
  localparam logic [1:0] SEL_OFFSET = 2'h2;
  localparam logic [1:0] SEL_GAIN = 2'h1;
  localparam logic [1:0] SEL_SPECIAL = 2'h0;
  localparam logic [DATA_W-1:0] SOFT_RESET_WORD = 14'h3FFF;
  localparam logic [GRP_MSB-GRP_LSB:0] GRP_ALL = 4'h0;
  localparam logic [POS_MSB:0] POS_CODE_LOW_MAX = 4'h5;
  localparam logic [POS_MSB:0] POS_CODE_6 = 4'h8;
  localparam logic [POS_MSB:0] POS_CODE_7 = 4'h9;
  localparam logic [POS_W-1:0] POS_6 = 3'h6;
  localparam logic [POS_W-1:0] POS_7 = 3'h7;

  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] INPUT_RESET = 14'h0000;
  localparam logic [DATA_W-1:0] OFFSET_RESET = 14'h2000;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 13'h1FFF;
  localparam logic [DATA_W-1:0] CODE_MAX = 14'h3FFF;
  localparam logic [DATA_W-1:0] CODE_MIN = 14'h0000;
  localparam logic [CAL_W-1:0] CAL_OFFSET_ZERO = 17'h02000;
  localparam logic [CAL_W-1:0] CAL_CODE_MAX = 17'h03FFF;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_INPUT = 3'h1,
    OP_OFFSET = 3'h2,
    OP_GAIN = 3'h3,
    OP_STEP = 3'h4,
    OP_RESET = 3'h5
  } dwd_op_type;

  typedef struct packed {
    logic reg_select_hi;
    logic reg_select_lo;
    logic [DATA_W-1:0] write_data_word;
    logic [ADDR_W-1:0] write_address;
  } dwd_write_type;

  typedef struct packed {
    logic [DATA_W-1:0] channel_input_code;
    logic [DATA_W-1:0] offset_code;
    logic [GAIN_W-1:0] gain_code;
  } dwd_chan_type;

endpackage : dwd_pkg

/* verif/dwd_host.sv */
// Purpose: Host controller model issuing decoder writes
// Assumes: Same clock as the decoder
// Notes: Idle bus shows the inverted last word
`timescale 1ns/1ps
module dwd_host (
  // Clock
  ref_clk,
  // Write port
  write_valid,
  write_cmd
);
  input wire logic ref_clk;
  output logic write_valid;
  output dwd_pkg::dwd_write_type write_cmd;
  initial begin
    write_valid = 1'b0;
    write_cmd = '0;
  end
  task automatic send(input logic [1:0] sel, input logic [13:0] data, input logic [7:0] addr);
    @(posedge ref_clk);
    write_valid <= 1'b1;
    write_cmd <= {sel, data, addr};
    @(posedge ref_clk);
    write_valid <= 1'b0;
    write_cmd <= ~write_cmd;
  endtask : send
  // Unused step bits stay zero
  task automatic step(input logic up, input logic [6:0] amt, input logic [7:0] addr);
    send(2'h0, {5'h00, up, 1'b0, amt}, addr);
  endtask : step
endmodule : dwd_host

/* verif/dwd_monitor.sv */
// Purpose: Port assertions for the DAC write decoder
// Assumes: One ref_clk domain, rst_n active low
// Notes: Bound to dwd_decoder after the module
`timescale 1ns/1ps
module dwd_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Inputs
  input wire logic write_valid,
  input wire dwd_pkg::dwd_write_type write_cmd,
  input wire logic output_update,
  input wire logic [dwd_pkg::CH_IDX_W-1:0] rd_channel,
  // Outputs
  input wire dwd_pkg::dwd_chan_type rd_state,
  input wire logic [dwd_pkg::DATA_W-1:0] rd_calibrated_code,
  input wire logic outputs_grounded,
  input wire logic write_done,
  input wire logic write_ignored,
  input wire logic soft_reset_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] sel;
  logic [3:0] grp;
  logic [3:0] pos;
  logic pos_ok;
  logic srst;
  assign sel = {write_cmd.reg_select_hi, write_cmd.reg_select_lo};
  assign grp = write_cmd.write_address[7:4];
  assign pos = write_cmd.write_address[3:0];
  assign pos_ok = (grp == 4'h0) || (pos <= 4'h5) || (pos == 4'h8) || (pos == 4'h9);
  assign srst = write_valid && (sel == 2'h0) && (write_cmd.write_data_word == 14'h3FFF);
  // -----------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------
  write_applied_a: assert property ((write_valid && (pos_ok || srst)) |=> write_done && !write_ignored)
    else $error("write not applied");
  bad_pos_a: assert property ((write_valid && !pos_ok && !srst) |=> write_ignored && !write_done)
    else $error("bad position not ignored");
  idle_quiet_a: assert property (!write_valid |=> !write_done && !write_ignored && !soft_reset_done)
    else $error("pulse without write");
  soft_reset_a: assert property (srst |=> soft_reset_done && outputs_grounded)
    else $error("soft reset not executed");
  step_kept_a: assert property ((write_valid && sel == 2'h0 && !srst) |=> !soft_reset_done)
    else $error("step taken as soft reset");
  ground_release_a: assert property ((outputs_grounded && output_update && !srst) |=> !outputs_grounded)
    else $error("ground not released");
  input_all_a: assert property ((write_valid && sel == 2'h3 && grp == 4'h0) |->
    ##2 rd_state.channel_input_code == $past(write_cmd.write_data_word, 2)) else $error("input write lost");
  offset_all_a: assert property ((write_valid && sel == 2'h2 && grp == 4'h0) |->
    ##2 rd_state.offset_code == $past(write_cmd.write_data_word, 2)) else $error("offset write lost");
  gain_all_a: assert property ((write_valid && sel == 2'h1 && grp == 4'h0) |->
    ##2 rd_state.gain_code == $past(write_cmd.write_data_word[12:0], 2)) else $error("gain write lost");
  cover property (srst);
  cover property (write_valid && !pos_ok && !srst);
  cover property (write_valid && sel == 2'h0 && !srst);
endmodule : dwd_monitor

bind dwd_decoder dwd_monitor mon (.ref_clk(ref_clk), .rst_n(rst_n), .write_valid(write_valid),
  .write_cmd(write_cmd), .output_update(output_update), .rd_channel(rd_channel), .rd_state(rd_state),
  .rd_calibrated_code(rd_calibrated_code), .outputs_grounded(outputs_grounded), .write_done(write_done),
  .write_ignored(write_ignored), .soft_reset_done(soft_reset_done));

/* verif/testbench.sv */
// Purpose: Self-checking bench for the DAC write decoder
// Assumes: Host model drives writes, bench drives the rest
// Notes: Read-back waits three edges for the calibrated code
`timescale 1ns/1ps
module testbench;
  logic ref_clk;
  logic rst_n;
  logic output_update;
  logic [dwd_pkg::CH_IDX_W-1:0] rd_channel;
  logic write_valid;
  dwd_pkg::dwd_write_type write_cmd;
  dwd_pkg::dwd_chan_type rd_state;
  logic [dwd_pkg::DATA_W-1:0] cal;
  logic grounded;
  logic done;
  logic ignored;
  logic srst_done;
  int fail_count;
  int checks;
  localparam logic [40:0] DEF = {dwd_pkg::INPUT_RESET, dwd_pkg::OFFSET_RESET, dwd_pkg::GAIN_RESET};
  dwd_host host (.ref_clk(ref_clk), .write_valid(write_valid), .write_cmd(write_cmd));
  dwd_decoder dut (.ref_clk(ref_clk), .rst_n(rst_n), .write_valid(write_valid), .write_cmd(write_cmd),
    .output_update(output_update), .rd_channel(rd_channel), .rd_state(rd_state), .rd_calibrated_code(cal),
    .outputs_grounded(grounded), .write_done(done), .write_ignored(ignored), .soft_reset_done(srst_done));
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  // -----------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input int ch);
    @(posedge ref_clk);
    rd_channel <= ch[4:0];
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : rd
  task automatic flags(input logic [2:0] exp);
    #1;
    chk({done, ignored, srst_done}, exp);
  endtask : flags
  task automatic test_done;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // -----------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------
  task automatic t_reset;
    rd(0);
    chk(rd_state, DEF);
    chk(grounded, 1'b1);
    rd(31);
    chk(rd_state, DEF);
  endtask : t_reset
  task automatic t_positions;
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
    for (int i = 0; i < 8; i++) begin
      host.send(2'h3, 14'h0100 + i, {4'h8, codes[i]});
      flags(3'b100);
      rd(24 + i);
      chk(rd_state.channel_input_code, 14'h0100 + i);
      chk(cal, 14'h0100 + i);
    end
  endtask : t_positions
  task automatic t_groups;
    logic [13:0] last [4] = '{14'h0000, 14'h0000, 14'h0000, 14'h0101};
    for (int g = 1; g < 16; g++) begin
      host.send(2'h3, g, {g[3:0], 4'h1});
      for (int k = 0; k < 4; k++) begin
        if (g[k]) last[k] = g;
        rd(k * 8 + 1);
        chk(rd_state.channel_input_code, last[k]);
      end
    end
  endtask : t_groups
  task automatic t_bad;
    for (int c = 6; c < 16; c++) begin
      if (c != 8 && c != 9) begin
        host.send(2'h3, 14'h1111, {4'hF, c[3:0]});
        flags(3'b010);
      end
    end
    rd(6);
    chk(rd_state, DEF);
  endtask : t_bad
  task automatic t_all;
    host.send(2'h2, 14'h3FFF, 8'h0F);
    host.send(2'h1, 14'h2005, 8'h0B);
    host.send(2'h3, 14'h3F80, 8'h06);
    flags(3'b100);
    rd(13);
    chk(rd_state, {14'h3F80, 14'h3FFF, 13'h0005});
    chk(cal, 14'h200A);
  endtask : t_all
  task automatic t_step;
    logic [21:0] tbl [7] = '{{1'b1, 7'h7F, 14'h3FFF}, {1'b1, 7'h01, 14'h3FFF}, {1'b0, 7'h7F, 14'h3F80},
      {1'b0, 7'h00, 14'h3F80}, {1'b1, 7'h03, 14'h3F83}, {1'b0, 7'h7F, 14'h3F04}, {1'b0, 7'h7F, 14'h3E85}};
    for (int i = 0; i < 7; i++) begin
      host.step(tbl[i][21], tbl[i][20:14], 8'h00);
      rd(i + 3);
      chk(rd_state.channel_input_code, tbl[i][13:0]);
    end
    host.send(2'h3, 14'h0005, 8'h00);
    host.step(1'b0, 7'h07, 8'h22);
    rd(10);
    chk(rd_state.channel_input_code, 14'h0000);
  endtask : t_step
  task automatic t_sreset;
    @(posedge ref_clk);
    output_update <= 1'b1;
    @(posedge ref_clk);
    output_update <= 1'b0;
    #1;
    chk(grounded, 1'b0);
    host.send(2'h0, 14'h3FFF, 8'h16);
    flags(3'b101);
    chk(grounded, 1'b1);
    rd(13);
    chk(rd_state, DEF);
    chk(cal, 14'h0000);
  endtask : t_sreset
  initial begin
    fail_count = 0;
    checks = 0;
    rst_n = 1'b0;
    output_update = 1'b0;
    rd_channel = '0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_positions();
    t_groups();
    t_bad();
    t_all();
    t_step();
    t_sreset();
    test_done();
  end
  initial begin
    #200us;
    fail_count++;
    test_done();
  end
endmodule : testbench
